// ===== inc/can_fault_consts.svh
`ifndef CAN_FAULT_CONSTS_SVH
`define CAN_FAULT_CONSTS_SVH

// byte addresses of the word-aligned registers
`define ADDR_TX_COUNT 12'h000
`define ADDR_RX_COUNT 12'h004
`define ADDR_TIMING_PRESCALE 12'h008
`define ADDR_TIMING_SEGMENTS 12'h00c
`define ADDR_MAILBOX_CTRL 12'h010
`define ADDR_FILTER_MATCH 12'h014
`define ADDR_IDENT_FIRST 12'h018
`define ADDR_IDENT_SECOND 12'h01c
`define ADDR_IDENT_THIRD 12'h020
`define ADDR_IDENT_FOURTH 12'h024
`define ADDR_FAULT_STATE 12'h028
`define ADDR_MODE_CTRL 12'h02c

`define RESET_PRESCALE 8'h40
`define RESET_SEGMENTS 8'h23

// fault counter figures
`define TX_ERR_STEP 9'h008
`define RX_ERR_BIG 8'h08
`define RX_ERR_SMALL 8'h01
`define PASSIVE_LIMIT 8'h7f
`define RX_HIGH_LIMIT 8'h80
`define RX_RELOAD 8'h78

// timing field positions
`define SJW_HI 7
`define SJW_LO 6
`define BRP_HI 5
`define BRP_LO 0
`define CLKSEL_BIT 7
`define SEG2_HI 6
`define SEG2_LO 4
`define SEG1_HI 3
`define SEG1_LO 0

// mailbox control/status bits
`define MB_ERR_BIT 5
`define MB_ARB_BIT 4
`define MB_OK_BIT 3
`define MB_DONE_BIT 2
`define MB_ABORT_BIT 1
`define MB_SEND_BIT 0

// mode register: initialization mode flag
`define MODE_INIT_BIT 0

// identifier register one bits
`define ID_EXT_BIT 6
`define ID_REMOTE_BIT 5
`define ID_TOP_HI 4
`define ID_TOP_LO 0

`endif

// ===== inc/can_fault_pkg.sv
package can_fault_pkg;
  // fault confinement state, gray along active -> passive -> bus-off
  typedef enum logic [1:0] {
    FAULT_ACTIVE = 2'b00,
    FAULT_PASSIVE = 2'b01,
    FAULT_BUSOFF = 2'b11
  } fault_state_e;

  // outcome of a transmission attempt reported by the protocol engine
  typedef enum logic [1:0] {
    TX_OUT_OK = 2'b00,
    TX_OUT_ERROR = 2'b01,
    TX_OUT_ARB_LOST = 2'b11
  } tx_outcome_e;
endpackage

// ===== rtl/quantum_divider.sv
`include "can_fault_consts.svh"

// divides the selected kernel clock tick by prescale+1 into a quantum tick
module quantum_divider (
  input wire logic clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic clkEn, // freezes state while low
  input wire logic kernelTick, // one pulse per kernel clock period
  input wire logic [5:0] divide, // quantum prescaler field
  output logic quantumTick // one pulse per time quantum
);
  logic [5:0] count_ff;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_ff <= 6'h00;
      quantumTick <= 1'b0;
    end else if (clkEn) begin
      quantumTick <= 1'b0;
      if (kernelTick) begin
        if (count_ff >= divide) begin
          count_ff <= 6'h00;
          quantumTick <= 1'b1;
        end else begin
          count_ff <= count_ff + 6'h01;
        end
      end
    end
  end
endmodule // quantum_divider

// ===== rtl/can_fault_timing_mailbox_ctrl.sv
// The APB register port and the address map are this design's own decisions.
`include "can_fault_consts.svh"

module can_fault_timing_mailbox_ctrl (
  input wire logic clk, // system clock, 10 MHz
  input wire logic arst_n, // async reset, active low
  input wire logic clkEn, // freezes all state while low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic extTick, // divided crystal clock tick
  input wire logic txError, // engine: transmit error, adds 8
  input wire logic txSuccess, // engine: frame sent
  input wire logic rxError, // engine: receive error
  input wire logic rxErrorBig, // with rxError: add 8 instead of 1
  input wire logic rxSuccess, // engine: frame received
  input wire logic busOffRecover, // engine: bus-off recovery done
  input wire logic txAttemptDone, // engine: attempt finished
  input wire logic [1:0] txOutcome, // engine: attempt outcome
  input wire logic abortDone, // engine: abort performed
  input wire logic rxMailboxSel, // page shows receive mailbox
  input wire logic [7:0] rxMatchIndex, // filter match number from engine
  output logic [1:0] faultState, // fault confinement state
  output logic sendPending, // transmit request to engine
  output logic abortPending, // abort request to engine
  output logic quantumTick, // one pulse per time quantum
  output logic [1:0] jumpWidth, // resync jump width field
  output logic [2:0] segTwoLen, // segment two field
  output logic [3:0] segOneLen // segment one field
);
  logic [7:0] txCount_ff;
  logic [7:0] rxCount_ff;
  logic busOff_ff;
  logic initMode_ff;
  logic [7:0] prescale_ff;
  logic [7:0] segments_ff;
  logic errFlag_ff;
  logic arbFlag_ff;
  logic okFlag_ff;
  logic doneFlag_ff;
  logic abortBit_ff;
  logic sendBit_ff;
  logic [7:0] ident1_ff;
  logic [7:0] ident2_ff;
  logic [7:0] ident3_ff;
  logic [7:0] ident4_ff;
  logic kernelTick;
  logic quantumRaw;
  logic wrEn;
  logic rdEn;
  logic mbEmpty;
  logic mbWrOk;
  logic clrDone;
  logic [8:0] nxt_txSum;
  logic [7:0] nxt_rxCount;
  logic [31:0] nxt_rdata;
  logic nxt_err;

  assign wrEn = psel && penable && pwrite && clkEn;
  assign rdEn = psel && !penable && !pwrite;
  assign mbEmpty = !sendBit_ff;
  assign mbWrOk = wrEn && !rxMailboxSel && mbEmpty;
  assign clrDone = wrEn && !rxMailboxSel && (paddr == `ADDR_MAILBOX_CTRL) && pwdata[`MB_DONE_BIT];

  // kernel clock select: cpu clock ticks every cycle
  assign kernelTick = segments_ff[`CLKSEL_BIT] ? extTick : 1'b1;

  quantum_divider quantumDiv (
    .clk(clk),
    .arst_n(arst_n),
    .clkEn(clkEn),
    .kernelTick(kernelTick),
    .divide(prescale_ff[`BRP_HI:`BRP_LO]),
    .quantumTick(quantumRaw)
  );

  // transmit count and bus-off
  always_comb begin
    nxt_txSum = {1'b0, txCount_ff};
    if (txError) begin
      nxt_txSum = {1'b0, txCount_ff} + `TX_ERR_STEP;
    end else if (txSuccess && txCount_ff != 8'h00) begin
      nxt_txSum = {1'b0, txCount_ff} - 9'h001;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txCount_ff <= 8'h00;
      busOff_ff <= 1'b0;
    end else if (clkEn) begin
      if (busOff_ff) begin
        if (busOffRecover) begin
          busOff_ff <= 1'b0;
          txCount_ff <= 8'h00;
        end
      end else if (nxt_txSum[8]) begin
        busOff_ff <= 1'b1;
        txCount_ff <= nxt_txSum[7:0];
      end else begin
        txCount_ff <= nxt_txSum[7:0];
      end
    end
  end

  // receive count
  always_comb begin
    nxt_rxCount = rxCount_ff;
    if (rxError) begin
      if (rxErrorBig) begin
        nxt_rxCount = (rxCount_ff > 8'hff - `RX_ERR_BIG) ? 8'hff : rxCount_ff + `RX_ERR_BIG;
      end else begin
        nxt_rxCount = (rxCount_ff == 8'hff) ? 8'hff : rxCount_ff + `RX_ERR_SMALL;
      end
    end else if (rxSuccess) begin
      if (rxCount_ff > `RX_HIGH_LIMIT) begin
        nxt_rxCount = `RX_RELOAD;
      end else if (rxCount_ff != 8'h00) begin
        nxt_rxCount = rxCount_ff - 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rxCount_ff <= 8'h00;
    end else if (clkEn) begin
      rxCount_ff <= nxt_rxCount;
    end
  end

  // fault state output
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      faultState <= can_fault_pkg::FAULT_ACTIVE;
    end else if (clkEn) begin
      if (busOff_ff) begin
        faultState <= can_fault_pkg::FAULT_BUSOFF;
      end else if (txCount_ff > `PASSIVE_LIMIT || rxCount_ff > `PASSIVE_LIMIT) begin
        faultState <= can_fault_pkg::FAULT_PASSIVE;
      end else begin
        faultState <= can_fault_pkg::FAULT_ACTIVE;
      end
    end
  end

  // mode and timing registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      initMode_ff <= 1'b1;
      prescale_ff <= `RESET_PRESCALE;
      segments_ff <= `RESET_SEGMENTS;
    end else if (wrEn) begin
      if (paddr == `ADDR_MODE_CTRL) begin
        initMode_ff <= pwdata[`MODE_INIT_BIT];
      end else if (paddr == `ADDR_TIMING_PRESCALE && initMode_ff) begin
        prescale_ff <= pwdata[7:0];
      end else if (paddr == `ADDR_TIMING_SEGMENTS && initMode_ff) begin
        segments_ff <= pwdata[7:0];
      end
    end
  end

  // timing fields out
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      jumpWidth <= 2'h0;
      segTwoLen <= 3'h0;
      segOneLen <= 4'h0;
      quantumTick <= 1'b0;
    end else if (clkEn) begin
      jumpWidth <= prescale_ff[`SJW_HI:`SJW_LO];
      segTwoLen <= segments_ff[`SEG2_HI:`SEG2_LO];
      segOneLen <= segments_ff[`SEG1_HI:`SEG1_LO];
      quantumTick <= quantumRaw;
    end
  end

  // mailbox request bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sendBit_ff <= 1'b0;
      abortBit_ff <= 1'b0;
    end else if (clkEn) begin
      if (txAttemptDone && can_fault_pkg::tx_outcome_e'(txOutcome) == can_fault_pkg::TX_OUT_OK || abortDone) begin
        sendBit_ff <= 1'b0;
        abortBit_ff <= 1'b0;
      end else if (wrEn && !rxMailboxSel && paddr == `ADDR_MAILBOX_CTRL) begin
        if (mbEmpty && pwdata[`MB_SEND_BIT]) begin
          sendBit_ff <= 1'b1;
        end
        if (!mbEmpty && pwdata[`MB_ABORT_BIT]) begin
          abortBit_ff <= 1'b1;
        end
      end
    end
  end

  // mailbox status flags; a finish in the clear cycle wins
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      errFlag_ff <= 1'b0;
      arbFlag_ff <= 1'b0;
      okFlag_ff <= 1'b0;
      doneFlag_ff <= 1'b0;
    end else if (clkEn) begin
      if (txAttemptDone) begin
        errFlag_ff <= txOutcome == can_fault_pkg::TX_OUT_ERROR;
        arbFlag_ff <= txOutcome == can_fault_pkg::TX_OUT_ARB_LOST;
        okFlag_ff <= txOutcome == can_fault_pkg::TX_OUT_OK;
        // a failed attempt stays pending and is retried
        doneFlag_ff <= doneFlag_ff || txOutcome == can_fault_pkg::TX_OUT_OK;
      end else if (abortDone) begin
        doneFlag_ff <= 1'b1;
      end else if (clrDone) begin
        doneFlag_ff <= 1'b0;
        errFlag_ff <= 1'b0;
        arbFlag_ff <= 1'b0;
        okFlag_ff <= 1'b0;
      end else if (mbWrOk && paddr == `ADDR_MAILBOX_CTRL && pwdata[`MB_SEND_BIT]) begin
        doneFlag_ff <= 1'b0;
      end
    end
  end

  // identifier registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ident1_ff <= 8'h00;
      ident2_ff <= 8'h00;
      ident3_ff <= 8'h00;
      ident4_ff <= 8'h00;
    end else if (mbWrOk) begin
      if (paddr == `ADDR_IDENT_FIRST) begin
        ident1_ff <= {1'b0, pwdata[`ID_EXT_BIT], pwdata[`ID_REMOTE_BIT], pwdata[`ID_TOP_HI:`ID_TOP_LO]};
      end else if (paddr == `ADDR_IDENT_SECOND) begin
        ident2_ff <= pwdata[7:0];
      end else if (paddr == `ADDR_IDENT_THIRD) begin
        ident3_ff <= pwdata[7:0];
      end else if (paddr == `ADDR_IDENT_FOURTH) begin
        ident4_ff <= pwdata[7:0];
      end
    end
  end

  // engine request outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sendPending <= 1'b0;
      abortPending <= 1'b0;
    end else if (clkEn) begin
      sendPending <= sendBit_ff;
      abortPending <= abortBit_ff;
    end
  end

  // read decode
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_err = 1'b0;
    if (paddr == `ADDR_TX_COUNT) begin
      nxt_rdata[7:0] = txCount_ff;
    end else if (paddr == `ADDR_RX_COUNT) begin
      nxt_rdata[7:0] = rxCount_ff;
    end else if (paddr == `ADDR_TIMING_PRESCALE) begin
      nxt_rdata[7:0] = initMode_ff ? prescale_ff : 8'h00;
      nxt_err = !initMode_ff;
    end else if (paddr == `ADDR_TIMING_SEGMENTS) begin
      nxt_rdata[7:0] = initMode_ff ? segments_ff : 8'h00;
      nxt_err = !initMode_ff;
    end else if (paddr == `ADDR_MAILBOX_CTRL) begin
      nxt_rdata[7:0] = {2'b00, errFlag_ff, arbFlag_ff, okFlag_ff, doneFlag_ff, abortBit_ff, sendBit_ff};
    end else if (paddr == `ADDR_FILTER_MATCH) begin
      nxt_rdata[7:0] = rxMatchIndex;
    end else if (paddr == `ADDR_IDENT_FIRST) begin
      nxt_rdata[7:0] = ident1_ff;
    end else if (paddr == `ADDR_IDENT_SECOND) begin
      nxt_rdata[7:0] = ident2_ff;
    end else if (paddr == `ADDR_IDENT_THIRD) begin
      nxt_rdata[7:0] = ident3_ff;
    end else if (paddr == `ADDR_IDENT_FOURTH) begin
      nxt_rdata[7:0] = ident4_ff;
    end else if (paddr == `ADDR_FAULT_STATE) begin
      nxt_rdata[3:0] = {mbEmpty, busOff_ff, faultState};
    end else if (paddr == `ADDR_MODE_CTRL) begin
      nxt_rdata[`MODE_INIT_BIT] = initMode_ff;
    end else begin
      nxt_err = 1'b1;
    end
  end

  // apb answer: no wait state, ready in the first access cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && nxt_err;
      if (rdEn) begin
        prdata <= nxt_rdata;
      end
    end
  end
endmodule // can_fault_timing_mailbox_ctrl

// ===== testbench/can_fault_monitor.sv
`include "can_fault_consts.svh"

module can_fault_mon (
  input wire logic clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic txAttemptDone, // attempt finished
  input wire logic [1:0] txOutcome, // attempt outcome
  input wire logic rxMailboxSel, // receive page
  input wire logic sendPending, // send request out
  input wire logic abortPending, // abort request out
  input wire logic [1:0] jumpWidth, // jump width field
  input wire logic [2:0] segTwoLen, // segment two field
  input wire logic [3:0] segOneLen // segment one field
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  wire logic mbWr = psel && penable && pwrite && paddr == `ADDR_MAILBOX_CTRL;
  wire logic psWr = psel && penable && pwrite && paddr == `ADDR_TIMING_PRESCALE;
  wire logic sgWr = psel && penable && pwrite && paddr == `ADDR_TIMING_SEGMENTS;
  wire logic okDone = txAttemptDone && txOutcome == can_fault_pkg::TX_OUT_OK;

  chk_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_unmapped_error: assert property (psel && !penable && paddr >= 12'h030 |=> pslverr)
    else $error("unmapped access without error");
  chk_send_sets: assert property (
    mbWr && pwdata[0] && !rxMailboxSel && !sendPending |-> ##[1:2] sendPending)
    else $error("send request not raised");
  chk_rx_write_ignored: assert property (
    mbWr && pwdata[0] && rxMailboxSel && !sendPending |=> !sendPending ##1 !sendPending)
    else $error("receive page accepted a write");
  chk_abort_idle_ignored: assert property (
    mbWr && pwdata[1] && !pwdata[0] && !sendPending |=> !abortPending ##1 !abortPending)
    else $error("abort taken with nothing pending");
  chk_ok_clears_send: assert property (okDone |-> ##2 !sendPending && !abortPending)
    else $error("send not cleared after success");
  chk_fail_keeps_send: assert property (
    txAttemptDone && !okDone && sendPending && !abortPending |-> ##2 sendPending)
    else $error("failed attempt dropped request");
  // a written field may land one or two cycles after the access
  chk_jump_held: assert property (
    !psWr && !$past(psWr) && !$past(psWr, 2) && $past(arst_n, 3) |-> $stable(jumpWidth))
    else $error("jump width moved without write");
  chk_segments_held: assert property (
    !sgWr && !$past(sgWr) && !$past(sgWr, 2) && $past(arst_n, 3) |-> $stable({segTwoLen, segOneLen}))
    else $error("segments moved without write");

  cov_ok_attempt: cover property (okDone && sendPending);
  cov_fail_attempt: cover property (txAttemptDone && !okDone);
  cov_abort: cover property ($rose(abortPending));
  cov_slverr: cover property (pready && pslverr);
endmodule // can_fault_mon

bind can_fault_timing_mailbox_ctrl can_fault_mon u_mon (.*);

// ===== testbench/can_engine_model.sv
module can_engine_model (
  input wire logic clk, // clock
  input wire logic sendPending, // transmit request
  input wire logic abortPending, // abort request
  output logic [4:0] ev, // txErr send_success_flag rxErr rxOk recover
  output logic big, // receive error adds 8
  output logic attemptDone, // attempt finished
  output logic [1:0] outcome, // attempt outcome
  output logic abortDone // abort performed
);
  timeunit 1ns;
  timeprecision 1ns;
  logic armed_ff = 1'b0;
  logic abSeen_ff = 1'b0;
  logic [1:0] want_ff = 2'b00;
  logic [3:0] lag_ff = 4'h0;
  initial begin
    ev = 5'h00;
    big = 1'b0;
    attemptDone = 1'b0;
    outcome = 2'b00;
    abortDone = 1'b0;
  end
  task automatic fire(input logic [4:0] e, input logic b);
    @(posedge clk);
    ev <= e;
    big <= b;
    @(posedge clk);
    ev <= 5'h00;
  endtask
  // one attempt per arm, so a failing outcome does not retry forever
  task automatic arm(input logic [1:0] o, input logic [3:0] l);
    @(posedge clk);
    want_ff <= o;
    lag_ff <= l;
    armed_ff <= 1'b1;
  endtask
  always @(posedge clk) begin
    attemptDone <= 1'b0;
    abortDone <= 1'b0;
    if (armed_ff && sendPending) begin
      if (lag_ff != 4'h0) begin
        lag_ff <= lag_ff - 4'h1;
      end else begin
        armed_ff <= 1'b0;
        attemptDone <= 1'b1;
        outcome <= want_ff;
      end
    end
    abSeen_ff <= abortPending;
    if (abortPending && !abSeen_ff) begin
      abortDone <= 1'b1;
    end
  end
endmodule // can_engine_model

// ===== testbench/can_fault_timing_mailbox_ctrl_tb.sv
`include "can_fault_consts.svh"

module can_fault_timing_mailbox_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, arst_n = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0, extTick = 0, rxMailboxSel = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, got;
  logic [7:0] rxMatchIndex = 8'h00, rnd = 8'h24, seg;
  logic pready, pslverr, sendPending, abortPending, quantumTick, big, attemptDone, abortDone, errSeen;
  logic [4:0] ev;
  logic [1:0] faultState, outcome, jumpWidth;
  logic [2:0] segTwoLen;
  logic [3:0] segOneLen;
  int mismatches = 0, checked = 0, cyc = 0, ticks;

  can_fault_timing_mailbox_ctrl dut (.clk(clk), .arst_n(arst_n), .clkEn(clkEn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .extTick(extTick), .txError(ev[0]), .txSuccess(ev[1]),
    .rxError(ev[2]), .rxErrorBig(big), .rxSuccess(ev[3]), .busOffRecover(ev[4]),
    .txAttemptDone(attemptDone), .txOutcome(outcome), .abortDone(abortDone),
    .rxMailboxSel(rxMailboxSel), .rxMatchIndex(rxMatchIndex), .faultState(faultState),
    .sendPending(sendPending), .abortPending(abortPending), .quantumTick(quantumTick),
    .jumpWidth(jumpWidth), .segTwoLen(segTwoLen), .segOneLen(segOneLen));
  can_engine_model u_eng (.clk(clk), .sendPending(sendPending), .abortPending(abortPending),
    .ev(ev), .big(big), .attemptDone(attemptDone), .outcome(outcome), .abortDone(abortDone));

  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    extTick <= (cyc % 5 == 0);
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    got = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 8'h00);
    check(got, {24'h0, exp});
  endtask
  // settle first: the divider may still be finishing a count of the old prescale
  task automatic count(input int n);
    repeat (130) @(posedge clk);
    ticks = 0;
    repeat (n) begin
      @(posedge clk);
      if (quantumTick === 1'b1) ticks++;
    end
  endtask

  initial begin
    #1000000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(`ADDR_TX_COUNT, 8'h00);
    rd(`ADDR_RX_COUNT, 8'h00);
    rd(`ADDR_TIMING_PRESCALE, `RESET_PRESCALE);
    rd(`ADDR_TIMING_SEGMENTS, `RESET_SEGMENTS);
    rd(`ADDR_MAILBOX_CTRL, 8'h00);
    rd(`ADDR_MODE_CTRL, 8'h01);
    rd(12'h030, 8'h00);
    check(errSeen, 1'b1);
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      seg = rnd ^ 8'h5a;
      apb(1'b1, `ADDR_TIMING_PRESCALE, rnd);
      apb(1'b1, `ADDR_TIMING_SEGMENTS, seg);
      rd(`ADDR_TIMING_PRESCALE, rnd);
      rd(`ADDR_TIMING_SEGMENTS, seg);
      check(jumpWidth, rnd[7:6]);
      check(segTwoLen, seg[6:4]);
      check(segOneLen, seg[3:0]);
    end
    apb(1'b1, `ADDR_TIMING_PRESCALE, 8'h03);
    apb(1'b1, `ADDR_TIMING_SEGMENTS, 8'h23);
    count(40);
    check(ticks, 10);
    apb(1'b1, `ADDR_TIMING_PRESCALE, 8'h01);
    apb(1'b1, `ADDR_TIMING_SEGMENTS, 8'ha3);
    count(100);
    check(ticks, 10);
    apb(1'b1, `ADDR_MODE_CTRL, 8'h00);
    apb(1'b1, `ADDR_TIMING_PRESCALE, 8'hc5);
    rd(`ADDR_TIMING_PRESCALE, 8'h00);
    check(errSeen, 1'b1);
    apb(1'b1, `ADDR_MODE_CTRL, 8'h01);
    rd(`ADDR_TIMING_PRESCALE, 8'h01);
    repeat (15) u_eng.fire(5'h01, 1'b0);
    rd(`ADDR_TX_COUNT, 8'h78);
    check(faultState, can_fault_pkg::FAULT_ACTIVE);
    u_eng.fire(5'h01, 1'b0);
    rd(`ADDR_TX_COUNT, 8'h80);
    check(faultState, can_fault_pkg::FAULT_PASSIVE);
    repeat (16) u_eng.fire(5'h01, 1'b0);
    rd(`ADDR_FAULT_STATE, 8'h0f);
    check(faultState, can_fault_pkg::FAULT_BUSOFF);
    u_eng.fire(5'h10, 1'b0);
    rd(`ADDR_TX_COUNT, 8'h00);
    repeat (2) u_eng.fire(5'h01, 1'b0);
    u_eng.fire(5'h02, 1'b0);
    rd(`ADDR_TX_COUNT, 8'h0f);
    check(faultState, can_fault_pkg::FAULT_ACTIVE);
    repeat (16) u_eng.fire(5'h04, 1'b1);
    rd(`ADDR_RX_COUNT, 8'h80);
    check(faultState, can_fault_pkg::FAULT_PASSIVE);
    u_eng.fire(5'h08, 1'b0);
    rd(`ADDR_RX_COUNT, 8'h7f);
    u_eng.fire(5'h04, 1'b1);
    u_eng.fire(5'h08, 1'b0);
    rd(`ADDR_RX_COUNT, 8'h78);
    u_eng.fire(5'h04, 1'b0);
    rd(`ADDR_RX_COUNT, 8'h79);
    // a low clock enable must swallow engine events, counters stay put
    clkEn <= 1'b0;
    u_eng.fire(5'h05, 1'b1);
    clkEn <= 1'b1;
    rd(`ADDR_RX_COUNT, 8'h79);
    rd(`ADDR_TX_COUNT, 8'h0f);
    rnd = lfsr(rnd);
    apb(1'b1, `ADDR_IDENT_FIRST, rnd);
    rd(`ADDR_IDENT_FIRST, rnd & 8'h7f);
    apb(1'b1, `ADDR_MAILBOX_CTRL, 8'h02);
    rd(`ADDR_MAILBOX_CTRL, 8'h00);
    apb(1'b1, `ADDR_MAILBOX_CTRL, 8'h01);
    apb(1'b1, `ADDR_IDENT_FIRST, ~rnd);
    rd(`ADDR_IDENT_FIRST, rnd & 8'h7f);
    rd(`ADDR_FAULT_STATE, 8'h00);
    u_eng.arm(can_fault_pkg::TX_OUT_ERROR, 4'd3);
    repeat (12) @(posedge clk);
    rd(`ADDR_MAILBOX_CTRL, 8'h21);
    apb(1'b1, `ADDR_MAILBOX_CTRL, 8'h02);
    repeat (8) @(posedge clk);
    rd(`ADDR_MAILBOX_CTRL, 8'h24);
    apb(1'b1, `ADDR_MAILBOX_CTRL, 8'h04);
    rd(`ADDR_MAILBOX_CTRL, 8'h00);
    apb(1'b1, `ADDR_MAILBOX_CTRL, 8'h01);
    u_eng.arm(can_fault_pkg::TX_OUT_ARB_LOST, 4'd0);
    repeat (8) @(posedge clk);
    rd(`ADDR_MAILBOX_CTRL, 8'h11);
    u_eng.arm(can_fault_pkg::TX_OUT_OK, 4'd6);
    repeat (14) @(posedge clk);
    rd(`ADDR_MAILBOX_CTRL, 8'h0c);
    rd(`ADDR_FAULT_STATE, 8'h08);
    apb(1'b1, `ADDR_MAILBOX_CTRL, 8'h01);
    apb(1'b0, `ADDR_MAILBOX_CTRL, 8'h00);
    check(got[2], 1'b0);
    u_eng.arm(can_fault_pkg::TX_OUT_OK, 4'd0);
    repeat (8) @(posedge clk);
    rd(`ADDR_MAILBOX_CTRL, 8'h0c);
    apb(1'b1, `ADDR_IDENT_FIRST, 8'h65);
    rd(`ADDR_IDENT_FIRST, 8'h65);
    rxMailboxSel <= 1'b1;
    rxMatchIndex <= rnd;
    apb(1'b1, `ADDR_IDENT_FIRST, 8'h12);
    rd(`ADDR_IDENT_FIRST, 8'h65);
    rd(`ADDR_FILTER_MATCH, rnd);
    apb(1'b1, `ADDR_MAILBOX_CTRL, 8'h01);
    rxMailboxSel <= 1'b0;
    rd(`ADDR_MAILBOX_CTRL, 8'h0c);
    give_verdict();
  end
endmodule // can_fault_timing_mailbox_ctrl_tb
